// >>> logic/hmi_regs.vh
// Purpose: register map and field constants for the host mac indirect access bank
// Assumes: byte addresses on a 32-bit register port
// Notes: definitions only
`ifndef HMI_REGS_VH
`define HMI_REGS_VH
`define HMI_OFS_DROP_COUNT 8'hA0
`define HMI_OFS_IND_CMD 8'hA4
`define HMI_OFS_IND_DATA 8'hA8
`define HMI_CMD_PENDING_BIT 31
`define HMI_CMD_DIR_BIT 30
`define HMI_CMD_ADDR_MSB 7
`define HMI_RST_DROP_COUNT 32'h00000000
`define HMI_RST_IND_DATA 32'h00000000
`define HMI_RST_IND_ADDR 8'h00
`define HMI_HALFWAY_FROM 32'h7FFFFFFF
`endif

// >>> logic/hmi_sync3.v
// Purpose: three-flop synchroniser for a level from outside the clock domain
// Assumes: one destination clock
// Notes: stable once second and third stages agree
`timescale 1ns/1ps
`default_nettype none
module hmi_sync3
(
   // clock and reset
   input wire sys_clk_i,
   input wire rst_n_i,
   // level
   input wire d_i,
   output reg q_o
);
   reg s1_reg;
   reg s2_reg;
   reg s3_reg;
   always @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         q_o <= 1'b0;
      end
      else
      begin
         s1_reg <= d_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg)
         begin
            q_o <= s3_reg;
         end
      end
   end
endmodule
`default_nettype wire

// >>> logic/hmi_bank.v
// Purpose: dropped-frame counter and indirect access port to host mac registers
// Assumes: single clock; mac register array answers with mac_ack_i
// Notes: drop event arrives as a toggle from the mac receive side
`timescale 1ns/1ps
`default_nettype none
`include "hmi_regs.vh"
module hmi_bank
(
   // clock and reset
   input wire sys_clk_i,
   input wire rst_n_i,
   // register port
   input wire reg_rd_i,
   input wire reg_wr_i,
   input wire [7:0] reg_addr_i,
   input wire [31:0] reg_wdata_i,
   output reg [31:0] reg_rdata_o,
   output reg reg_rvalid_o,
   // drop event toggle from receive path, other domain
   input wire drop_toggle_i,
   // halfway status towards interrupt status register bit 23
   output reg drop_count_halfway_irq_o,
   input wire halfway_clear_i,
   // host mac register array
   output reg mac_req_o,
   output reg mac_we_o,
   output reg [7:0] mac_addr_o,
   output reg [31:0] mac_wdata_o,
   input wire mac_ack_i,
   input wire [31:0] mac_rdata_i,
   // status
   output reg access_pending_o
);
   localparam ST_IDLE = 3'b001;
   localparam ST_REQ = 3'b010;
   localparam ST_WAIT = 3'b100;
   // ST_REQ spends one cycle so the request is built from the command just stored

   reg [2:0] state_reg;
   reg [31:0] dropped_frame_count_reg;
   reg direction_read_reg;
   reg [7:0] ind_addr_reg;
   reg [31:0] wr_data_reg;
   reg [31:0] rd_data_reg;
   reg drop_prev_reg;

   wire drop_lvl;
   wire drop_evt;
   wire cnt_rd;
   wire cmd_wr;
   wire data_wr;
   wire start;

   reg [31:0] rdata_next;

   // the drop toggle comes from the receive clock domain
   hmi_sync3 u_drop_sync
   (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .d_i(drop_toggle_i),
      .q_o(drop_lvl)
   );

   // both edge stages reset low like the idle pin, so reset makes no false drop
   assign drop_evt = drop_lvl ^ drop_prev_reg;
   assign cnt_rd = reg_rd_i && (reg_addr_i == `HMI_OFS_DROP_COUNT);
   // writes while pending are ignored so a misbehaving host cannot corrupt a transfer
   assign cmd_wr = reg_wr_i && (reg_addr_i == `HMI_OFS_IND_CMD) && !access_pending_o;
   assign data_wr = reg_wr_i && (reg_addr_i == `HMI_OFS_IND_DATA) && !access_pending_o;
   assign start = cmd_wr && reg_wdata_i[`HMI_CMD_PENDING_BIT];

   // drop counter; an event in the read cycle survives as the new count of one
   always @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         drop_prev_reg <= 1'b0;
         dropped_frame_count_reg <= `HMI_RST_DROP_COUNT;
         drop_count_halfway_irq_o <= 1'b0;
      end
      else
      begin
         drop_prev_reg <= drop_lvl;
         if (cnt_rd)
         begin
            dropped_frame_count_reg <= {31'h00000000, drop_evt};
         end
         else if (drop_evt)
         begin
            dropped_frame_count_reg <= dropped_frame_count_reg + 32'h00000001;
         end
         // the flag is sticky; only the interrupt status side clears it
         // set wins over clear
         if (drop_evt && !cnt_rd && dropped_frame_count_reg == `HMI_HALFWAY_FROM)
         begin
            drop_count_halfway_irq_o <= 1'b1;
         end
         else if (halfway_clear_i)
         begin
            drop_count_halfway_irq_o <= 1'b0;
         end
      end
   end

   // command and data registers plus access sequencer
   always @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_reg <= ST_IDLE;
         access_pending_o <= 1'b0;
         direction_read_reg <= 1'b0;
         ind_addr_reg <= `HMI_RST_IND_ADDR;
         wr_data_reg <= `HMI_RST_IND_DATA;
         rd_data_reg <= `HMI_RST_IND_DATA;
         mac_req_o <= 1'b0;
         mac_we_o <= 1'b0;
         mac_addr_o <= `HMI_RST_IND_ADDR;
         mac_wdata_o <= `HMI_RST_IND_DATA;
      end
      else
      begin
         if (cmd_wr)
         begin
            direction_read_reg <= reg_wdata_i[`HMI_CMD_DIR_BIT];
            ind_addr_reg <= reg_wdata_i[`HMI_CMD_ADDR_MSB:0];
         end
         if (data_wr)
         begin
            wr_data_reg <= reg_wdata_i;
         end
         case (state_reg)
            ST_IDLE:
            begin
               if (start)
               begin
                  access_pending_o <= 1'b1;
                  state_reg <= ST_REQ;
               end
            end
            ST_REQ:
            begin
               mac_req_o <= 1'b1;
               mac_we_o <= !direction_read_reg;
               mac_addr_o <= ind_addr_reg;
               mac_wdata_o <= wr_data_reg;
               state_reg <= ST_WAIT;
            end
            ST_WAIT:
            begin
               // no timeout: a mac array that never answers leaves pending set
               if (mac_ack_i)
               begin
                  mac_req_o <= 1'b0;
                  mac_we_o <= 1'b0;
                  if (direction_read_reg)
                  begin
                     rd_data_reg <= mac_rdata_i;
                  end
                  access_pending_o <= 1'b0;
                  state_reg <= ST_IDLE;
               end
            end
            default:
            begin
               state_reg <= ST_IDLE;
               access_pending_o <= 1'b0;
               mac_req_o <= 1'b0;
               mac_we_o <= 1'b0;
            end
         endcase
      end
   end

   always @*
   begin
      rdata_next = 32'h00000000;
      // reserved command bits and unmapped offsets read as zero
      case (reg_addr_i)
         `HMI_OFS_DROP_COUNT: rdata_next = dropped_frame_count_reg;
         `HMI_OFS_IND_CMD: rdata_next = {access_pending_o, direction_read_reg,
            22'h000000, ind_addr_reg};
         `HMI_OFS_IND_DATA: rdata_next = direction_read_reg ? rd_data_reg : wr_data_reg;
         default: rdata_next = 32'h00000000;
      endcase
   end

   always @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         reg_rdata_o <= 32'h00000000;
         reg_rvalid_o <= 1'b0;
      end
      else
      begin
         // read data is held until the next read so the host may take it late
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i)
         begin
            reg_rdata_o <= rdata_next;
         end
      end
   end
endmodule
`default_nettype wire

// >>> test/hmi_mac_model.sv
// Purpose: host mac register array behind the indirect port
// Assumes: answers each request after dly_i idle cycles
// Notes: read data is inverted while no answer stands
`timescale 1ns/1ps
`default_nettype none
module hmi_mac_model
(
   input wire logic sys_clk_i,
   input wire logic [3:0] dly_i,
   input wire logic req_i,
   input wire logic we_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   output logic ack_o,
   output logic [31:0] rdata_o
);
   logic [31:0] mem [0:255];
   logic [31:0] q = 32'h0;
   logic [3:0] cnt = 4'h0;
   logic ack_q = 1'b0;
   assign ack_o = ack_q;
   assign rdata_o = ack_o ? q : ~q;
   always @(posedge sys_clk_i)
   begin
      ack_q <= 1'b0;
      if (req_i && !ack_q)
      begin
         cnt <= cnt + 4'h1;
         if (cnt == dly_i)
         begin
            ack_q <= 1'b1;
            cnt <= 4'h0;
            q <= mem[addr_i];
            if (we_i)
            begin
               mem[addr_i] <= wdata_i;
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> test/hmi_bank_assertions.sv
// Purpose: port checks for hmi_bank
// Assumes: one clock, asynchronous active-low reset
// Notes: bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module hmi_bank_assertions
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic reg_rd_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic reg_rvalid_o,
   input wire logic mac_req_o,
   input wire logic mac_we_o,
   input wire logic [7:0] mac_addr_o,
   input wire logic [31:0] mac_wdata_o,
   input wire logic mac_ack_i,
   input wire logic access_pending_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   logic go;
   assign go = reg_wr_i && reg_addr_i == 8'hA4 && reg_wdata_i[31] && !access_pending_o;
   a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
      else $error("read not answered");
   a_read_quiet: assert property (!reg_rd_i |=> !reg_rvalid_o)
      else $error("read answer without read");
   a_start_access: assert property (go |=> access_pending_o ##1 mac_req_o)
      else $error("access did not start");
   a_request_fields: assert property (go |=> ##1 mac_we_o == !$past(reg_wdata_i[30], 2)
      && mac_addr_o == $past(reg_wdata_i[7:0], 2)) else $error("wrong request fields");
   a_pending_holds: assert property (access_pending_o && !(mac_req_o && mac_ack_i)
      |=> access_pending_o) else $error("pending dropped early");
   a_pending_clears: assert property (mac_req_o && mac_ack_i
      |=> !access_pending_o && !mac_req_o) else $error("pending not cleared");
   a_request_stable: assert property (mac_req_o && !mac_ack_i
      |=> mac_req_o && $stable({mac_we_o, mac_addr_o, mac_wdata_o})) else $error("request moved");
   a_request_pending: assert property (mac_req_o |-> access_pending_o)
      else $error("request without pending");
   a_cmd_reserved: assert property (reg_rd_i && reg_addr_i == 8'hA4
      |=> reg_rdata_o[29:8] == 22'h0) else $error("reserved bits set");
endmodule
`default_nettype wire

// >>> test/hmi_bank_test.sv
// Purpose: self-checking bench for hmi_bank
// Assumes: 200 MHz clock, model answers after a set delay
// Notes: halfway flag needs 2^31 drops and is not reached here
`timescale 1ns/1ps
`default_nettype none
module hmi_bank_test;
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic reg_wr_i = 1'b0;
   logic drop_toggle_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0;
   logic [31:0] reg_rdata_o, mac_wdata_o, mac_rdata_i;
   logic reg_rvalid_o, mac_req_o, mac_we_o, mac_ack_i, access_pending_o;
   logic drop_count_halfway_irq_o;
   logic halfway_clear_i = 1'b0;
   logic [7:0] mac_addr_o;
   logic [3:0] dly = 4'h0;
   int mismatches = 0, n_checks = 0, cyc = 0;
   always #2.5 sys_clk_i = ~sys_clk_i;
   hmi_bank dut (.sys_clk_i, .rst_n_i, .reg_rd_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
      .reg_rdata_o, .reg_rvalid_o, .drop_toggle_i, .drop_count_halfway_irq_o,
      .halfway_clear_i, .mac_req_o, .mac_we_o, .mac_addr_o, .mac_wdata_o,
      .mac_ack_i, .mac_rdata_i, .access_pending_o);
   hmi_mac_model u_mac (.sys_clk_i, .dly_i(dly), .req_i(mac_req_o), .we_i(mac_we_o),
      .addr_i(mac_addr_o), .wdata_i(mac_wdata_o), .ack_o(mac_ack_i), .rdata_o(mac_rdata_i));
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [32:0] e, input logic [32:0] s);
      n_checks++;
      if (s !== e)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
      @(posedge sys_clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      @(negedge sys_clk_i);
      chk($sformatf("read %h", a), {1'b1, e}, {reg_rvalid_o, reg_rdata_o});
      @(posedge sys_clk_i);
   endtask
   task automatic pend(input logic e);
      @(negedge sys_clk_i);
      chk("pending", {32'h0, e}, {32'h0, access_pending_o});
      @(posedge sys_clk_i);
   endtask
   task automatic halfway(input logic e);
      @(negedge sys_clk_i);
      chk("halfway flag", {32'h0, e}, {32'h0, drop_count_halfway_irq_o});
      @(posedge sys_clk_i);
   endtask
   always @(posedge sys_clk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         mismatches++;
         summarize();
      end
   end
   initial
   begin
      repeat (10) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      @(posedge sys_clk_i);
      rd(8'hA0, 32'h0);
      rd(8'hA4, 32'h0);
      rd(8'hA8, 32'h0);
      rd(8'h10, 32'h0);
      halfway(1'b0);
      $display("test reset values done");
      repeat (3)
      begin
         drop_toggle_i <= ~drop_toggle_i;
         repeat (6) @(posedge sys_clk_i);
      end
      rd(8'hA0, 32'h3);
      rd(8'hA0, 32'h0);
      halfway(1'b0);
      halfway_clear_i <= 1'b1;
      @(posedge sys_clk_i);
      halfway_clear_i <= 1'b0;
      halfway(1'b0);
      $display("test drop count done");
      wr(8'hA8, 32'hDEADBEEF);
      wr(8'hA4, 32'h80000012);
      repeat (6) @(posedge sys_clk_i);
      pend(1'b0);
      chk("mac write", {1'b0, 32'hDEADBEEF}, {1'b0, u_mac.mem[8'h12]});
      rd(8'hA8, 32'hDEADBEEF);
      wr(8'hA4, 32'h7FFFFF34);
      rd(8'hA4, 32'h40000034);
      wr(8'hA8, 32'h12345678);
      dly <= 4'h6;
      wr(8'hA4, 32'hC0000012);
      wr(8'hA4, 32'h00000099);
      wr(8'hA8, 32'h0);
      pend(1'b1);
      repeat (12) @(posedge sys_clk_i);
      pend(1'b0);
      rd(8'hA8, 32'hDEADBEEF);
      rd(8'hA4, 32'h40000012);
      $display("test indirect access done");
      summarize();
   end
endmodule
bind hmi_bank hmi_bank_assertions u_chk (.sys_clk_i, .rst_n_i, .reg_rd_i, .reg_wr_i,
   .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .mac_req_o, .mac_we_o,
   .mac_addr_o, .mac_wdata_o, .mac_ack_i, .access_pending_o);
`default_nettype wire
